// ==== hdl/cfp_config_fuse_protection.sv ====
// Behaviour
// - debug fuse 0 dedicates the two debug port pins; 1 leaves them general I/O
// - low-voltage programming fuse 1 enables low-voltage serial entry, 0 disables it
// - stack-fault fuse 1 lets stack full/underflow reset the device, 0 does not
// - unimplemented bits of the debug/stack byte read zero
// - larger variants: code guard bits 0-3 cover four 16 KB blocks from 000200
// - smallest variant: code guard bits 0-3 cover 000800-007FFF in 8 KB blocks
// - largest variant: code guard bits 4-7 cover 010000-01FFFF in 16 KB blocks
// - boot code guard covers 0-7FF small, 0-1FF larger; 0 protects
// - eeprom code guard 0 protects data eeprom, 1 leaves it open
// - eeprom and boot code guards start at 1 and may only be cleared
// - larger variants: write guard bits 0-3 block writes to the four low blocks
// - smallest variant: write guard bits 0-3 block writes to 8 KB blocks
// - largest variant: write guard bits 4-7 block writes to upper 16 KB blocks
// - boot write guard in high byte bit 6 blocks boot block writes when 0
// - eeprom write guard bit 7 blocks data eeprom writes when 0
// - config space guard 0 protects 300000-3000FF; read-only for user software
// - every implemented fuse reads 1 when unprogrammed: all open, debug off
// - unimplemented bits of high code and write guard bytes read zero
// - watchdog fuse 0 hands control to software enable; fuse 1 cannot be overridden
module cfp_config_fuse_protection
  import cfp_pkg::*;
#(
  parameter cfp_variant_t VARIANT = CFP_VAR_LARGE
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic userMode,
  input wire logic watchdog_fuse_enable,
  input wire logic [31:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [31:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic stackFault,
  input wire cfp_wreq_t flashReqIn,
  output cfp_wreq_t flashReqOut,
  output logic flashReqBlocked,
  output cfp_decode_t decoded,
  output logic debug_clock_port_pin,
  output logic debug_data_port_pin,
  output logic stackFaultReset,
  output logic watchdogRun
);

  // ****************************************************************
  // fuse storage (nonvolatile image, survives rst_n)
  // ****************************************************************
  logic [7:0] dbgCfg_r, cpLo_r, cpHi_r, wpLo_r, wpHi_r;
  // power-up state of the erase marker: the fuse image has no reset of its own
  logic fuseInit_r = 1'b0;
  logic wdtSw_r;
  logic [23:0] chkAddr_r;
  logic cfgGuardNow;

  // implemented-bit masks, upper blocks only on the largest variant
  localparam logic [7:0] LO_MASK = (VARIANT == CFP_VAR_LARGE) ? 8'hff : 8'h0f;

  // ****************************************************************
  // register bus slave
  // ****************************************************************
  logic awHeld_r, wHeld_r;
  logic [23:0] awAddr_r;
  logic [31:0] wData_r;
  logic [3:0] wStrb_r;
  logic doWrite;
  logic [1:0] wrResp;

  assign s_axi_awready = !awHeld_r && !s_axi_bvalid;
  assign s_axi_wready = !wHeld_r && !s_axi_bvalid;
  assign doWrite = awHeld_r && wHeld_r && !s_axi_bvalid;

  // address and data are caught independently, in either order
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      awHeld_r <= 1'b0;
      wHeld_r <= 1'b0;
      awAddr_r <= 24'h000000;
      wData_r <= 32'h00000000;
      wStrb_r <= 4'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        awHeld_r <= 1'b1;
        awAddr_r <= s_axi_awaddr[23:0];
      end else if (doWrite) begin
        awHeld_r <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wHeld_r <= 1'b1;
        wData_r <= s_axi_wdata;
        wStrb_r <= s_axi_wstrb;
      end else if (doWrite) begin
        wHeld_r <= 1'b0;
      end
    end
  end

  // byte lane of a 24-bit address inside its word
  function automatic logic [7:0] laneByte(input logic [31:0] d, input logic [1:0] a);
    laneByte = d[8*a +: 8];
  endfunction

  function automatic logic laneStrb(input logic [3:0] s, input logic [1:0] a);
    laneStrb = s[a];
  endfunction

  // word-aligned decode: the fuse bytes share two words, so the lane is the byte address
  function automatic logic [23:0] wordOf(input logic [23:0] a);
    wordOf = {a[23:2], 2'b00};
  endfunction

  logic wrCfgWord0, wrCfgWord1, wrCfgWord2, wrOwn;
  assign wrCfgWord0 = wordOf(awAddr_r) == wordOf(CFP_OFS_DBGCFG);
  assign wrCfgWord1 = wordOf(awAddr_r) == wordOf(CFP_OFS_CPLO);
  assign wrCfgWord2 = wordOf(awAddr_r) == wordOf(CFP_OFS_WPLO);
  assign wrOwn = (awAddr_r == CFP_OFS_CTRL) || (awAddr_r == CFP_OFS_WDT)
    || (awAddr_r == CFP_OFS_WCHK) || (awAddr_r == CFP_OFS_STAT);

  // config-space guard stops user-mode fuse writes; programmer mode ignores it
  assign cfgGuardNow = userMode && !wpHi_r[CFP_BIT_CFGSP];

  always_comb begin
    if (!(wrCfgWord0 || wrCfgWord1 || wrCfgWord2 || wrOwn)) begin
      wrResp = CFP_RESP_DECERR;
    end else if ((wrCfgWord0 || wrCfgWord1 || wrCfgWord2) && cfgGuardNow) begin
      wrResp = CFP_RESP_SLVERR;
    end else begin
      wrResp = CFP_RESP_OKAY;
    end
  end

  // write response, held until bready
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= CFP_RESP_OKAY;
    end else if (doWrite) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= wrResp;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  logic fuseWr;
  assign fuseWr = doWrite && (wrResp == CFP_RESP_OKAY);

  // ****************************************************************
  // fuse array: not cleared by rst_n, erased once after power-up
  // ****************************************************************
  // fuseInit_r is a one-shot marker: before the first reset the array reads erased
  always_ff @(posedge clock) begin
    if (!fuseInit_r) begin
      dbgCfg_r <= CFP_ERASED & CFP_MASK_DBGCFG;
      cpLo_r <= CFP_ERASED & LO_MASK;
      cpHi_r <= CFP_ERASED & CFP_MASK_CPHI;
      wpLo_r <= CFP_ERASED & LO_MASK;
      wpHi_r <= CFP_ERASED & CFP_MASK_WPHI;
    end else if (fuseWr) begin
      if (wrCfgWord0 && laneStrb(wStrb_r, 2'd2)) begin
        dbgCfg_r <= laneByte(wData_r, 2'd2) & CFP_MASK_DBGCFG;
      end
      if (wrCfgWord1 && laneStrb(wStrb_r, 2'd0)) begin
        // absent upper block bits read zero whatever the programmer sends
        cpLo_r <= laneByte(wData_r, 2'd0) & LO_MASK;
      end
      if (wrCfgWord1 && laneStrb(wStrb_r, 2'd1)) begin
        // clear-only: a 1 written cannot lift protection
        cpHi_r <= cpHi_r & laneByte(wData_r, 2'd1) & CFP_MASK_CPHI;
      end
      if (wrCfgWord2 && laneStrb(wStrb_r, 2'd2)) begin
        wpLo_r <= laneByte(wData_r, 2'd2) & LO_MASK;
      end
      if (wrCfgWord2 && laneStrb(wStrb_r, 2'd3)) begin
        if (userMode) begin
          // user mode cannot change the config-space guard bit
          wpHi_r <= {wData_r[31:30], wpHi_r[CFP_BIT_CFGSP], 5'h00};
        end else begin
          wpHi_r <= laneByte(wData_r, 2'd3) & CFP_MASK_WPHI;
        end
      end
    end
  end

  // one-shot erase marker: set by the first reset and never cleared again
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      fuseInit_r <= 1'b1;
    end
  end

  // ****************************************************************
  // decode, latched at reset
  // ****************************************************************
  function automatic cfp_decode_t decodeFuses(input logic [7:0] d, input logic [7:0] cl,
                                              input logic [7:0] ch, input logic [7:0] wl,
                                              input logic [7:0] wh);
    cfp_decode_t r;
    r.debugPinsDedicated = !d[CFP_BIT_DEBUG];
    r.lowVoltProgEnable = d[CFP_BIT_LVP];
    r.stackFaultResetEnable = d[CFP_BIT_STACK];
    r.codeGuard = ~(cl | ~LO_MASK);
    r.eepromCodeGuard = !ch[CFP_BIT_EEPROM];
    r.bootCodeGuard = !ch[CFP_BIT_BOOT];
    r.writeGuard = ~(wl | ~LO_MASK);
    r.eepromWriteGuard = !wh[CFP_BIT_EEPROM];
    r.bootWriteGuard = !wh[CFP_BIT_BOOT];
    r.configSpaceWriteGuard = !wh[CFP_BIT_CFGSP];
    decodeFuses = r;
  endfunction

  // sampled while reset is low so later fuse writes reach the decoded outputs only at the next reset
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      decoded <= decodeFuses(dbgCfg_r, cpLo_r, cpHi_r, wpLo_r, wpHi_r);
    end
  end

  // ****************************************************************
  // pins, stack reset, watchdog
  // ****************************************************************
  // pin ownership flags: 1 means given over to the debugger
  assign debug_clock_port_pin = decoded.debugPinsDedicated;
  assign debug_data_port_pin = decoded.debugPinsDedicated;
  assign stackFaultReset = stackFault && decoded.stackFaultResetEnable;

  logic wdtFuseSync1_r, wdtFuseSync2_r;
  // fuse level comes from outside this clock, so synchronise it
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      wdtFuseSync1_r <= 1'b0;
      wdtFuseSync2_r <= 1'b0;
    end else begin
      wdtFuseSync1_r <= watchdog_fuse_enable;
      wdtFuseSync2_r <= wdtFuseSync1_r;
    end
  end

  // software enable only matters when the fuse leaves the watchdog off
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      wdtSw_r <= 1'b0;
    end else if (doWrite && awAddr_r == CFP_OFS_WDT && wStrb_r[0]) begin
      wdtSw_r <= wData_r[0];
    end
  end
  assign watchdogRun = wdtFuseSync2_r || wdtSw_r;

  // ****************************************************************
  // write/erase gate and address check register
  // ****************************************************************
  function automatic logic isGuarded(input logic [23:0] a, input logic ee,
                                     input cfp_decode_t g);
    logic [20:0] fa;
    logic hit;
    fa = a[20:0];
    hit = 1'b0;
    if (ee) begin
      hit = g.eepromWriteGuard;
    end else if (a >= CFP_CFGSP_LO && a <= CFP_CFGSP_HI) begin
      hit = g.configSpaceWriteGuard;
    end else if (a[23:21] != 3'b000) begin
      hit = 1'b0;
    end else if (VARIANT == CFP_VAR_SMALL) begin
      if (fa <= CFP_BOOT_END_SMALL) begin
        hit = g.bootWriteGuard;
      end else if (fa <= CFP_SMALL_TOP) begin
        hit = g.writeGuard[fa[14:13]];
      end
    end else begin
      if (fa <= CFP_BOOT_END_LARGE) begin
        hit = g.bootWriteGuard;
      end else if (fa <= CFP_LARGE_TOP) begin
        hit = g.writeGuard[fa[15:14]];
      end else if (VARIANT == CFP_VAR_LARGE && fa <= CFP_UPPER_TOP) begin
        hit = g.writeGuard[{1'b1, fa[15:14]}];
      end
    end
    isGuarded = hit;
  endfunction

  logic reqHit;
  assign reqHit = flashReqIn.valid && isGuarded(flashReqIn.addr, flashReqIn.isEeprom, decoded);
  // suppressed requests never reach the array
  assign flashReqOut = '{valid: flashReqIn.valid && !reqHit, isEeprom: flashReqIn.isEeprom,
                         addr: flashReqIn.addr};
  assign flashReqBlocked = reqHit;

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      chkAddr_r <= {3'h0, CFP_CFG_BASE};
    end else if (doWrite && awAddr_r == CFP_OFS_WCHK) begin
      chkAddr_r <= wData_r[23:0];
    end
  end

  // ****************************************************************
  // read channel
  // ****************************************************************
  logic [31:0] rdData;
  logic [1:0] rdResp;
  always_comb begin
    rdData = 32'h00000000;
    rdResp = CFP_RESP_OKAY;
    case (wordOf(s_axi_araddr[23:0]))
      wordOf(CFP_OFS_DBGCFG): rdData = {8'h00, dbgCfg_r, 16'h0000};
      // code and write guard bytes share one word, lanes 0 to 3
      wordOf(CFP_OFS_CPLO): rdData = {wpHi_r, wpLo_r, cpHi_r, cpLo_r};
      CFP_OFS_CTRL: rdData = {31'h00000000, userMode};
      CFP_OFS_STAT: rdData = {8'h00, decoded};
      CFP_OFS_WDT: rdData = {30'h00000000, watchdogRun, wdtSw_r};
      CFP_OFS_WCHK: rdData = {7'h00, isGuarded(chkAddr_r, 1'b0, decoded), chkAddr_r};
      default: rdResp = CFP_RESP_DECERR;
    endcase
    if (s_axi_araddr[31:24] != 8'h00) begin
      rdData = 32'h00000000;
      rdResp = CFP_RESP_DECERR;
    end
  end

  assign s_axi_arready = !s_axi_rvalid;
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= CFP_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rdData;
      s_axi_rresp <= rdResp;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // ****************************************************************
  // checks
  // ****************************************************************
  a_pins_follow_fuse: assert property (@(posedge clock) disable iff (!rst_n)
    $rose(rst_n) |-> debug_data_port_pin == !$past(dbgCfg_r[CFP_BIT_DEBUG])
    && debug_clock_port_pin == debug_data_port_pin)
    else $error("debug pin ownership wrong");
  a_lvp_decode: assert property (@(posedge clock) disable iff (!rst_n)
    $rose(rst_n) |-> decoded.lowVoltProgEnable == $past(dbgCfg_r[CFP_BIT_LVP]))
    else $error("low-voltage enable mis-sampled");
  a_stack_reset: assert property (@(posedge clock) disable iff (!rst_n)
    stackFault && !decoded.stackFaultResetEnable |-> !stackFaultReset)
    else $error("stack reset while disabled");
  a_dbg_unimpl: assert property (@(posedge clock) disable iff (!rst_n)
    (dbgCfg_r & ~CFP_MASK_DBGCFG) == 8'h00)
    else $error("unimplemented debug bits set");
  a_hi_unimpl: assert property (@(posedge clock) disable iff (!rst_n)
    (cpHi_r & ~CFP_MASK_CPHI) == 8'h00 && (wpHi_r & ~CFP_MASK_WPHI) == 8'h00)
    else $error("unimplemented guard bits set");
  a_clear_only: assert property (@(posedge clock) disable iff (!rst_n)
    fuseInit_r && $past(fuseInit_r) |-> (cpHi_r & ~$past(cpHi_r)) == 8'h00)
    else $error("code guard bit was set back");
  a_held_stable: assert property (@(posedge clock) disable iff (!rst_n)
    $past(rst_n) |-> $stable(decoded))
    else $error("decoded outputs moved outside reset");
  a_blocked_req: assert property (@(posedge clock) disable iff (!rst_n)
    reqHit |-> !flashReqOut.valid ##0 flashReqBlocked)
    else $error("guarded write passed");
  a_wdt_fuse: assert property (@(posedge clock) disable iff (!rst_n)
    wdtFuseSync2_r |-> watchdogRun)
    else $error("watchdog stopped against fuse");

endmodule

// ==== hdl/cfp_pkg.sv ====
package cfp_pkg;

  // ****************************************************************
  // register map (byte addresses over the register bus)
  // ****************************************************************
  localparam logic [23:0] CFP_OFS_DBGCFG = 24'h300006;
  localparam logic [23:0] CFP_OFS_CPLO = 24'h300008;
  localparam logic [23:0] CFP_OFS_CPHI = 24'h300009;
  localparam logic [23:0] CFP_OFS_WPLO = 24'h30000a;
  localparam logic [23:0] CFP_OFS_WPHI = 24'h30000b;
  // own registers: mode control, decode status, watchdog, write check
  localparam logic [23:0] CFP_OFS_CTRL = 24'h300100;
  localparam logic [23:0] CFP_OFS_STAT = 24'h300104;
  localparam logic [23:0] CFP_OFS_WDT = 24'h300108;
  localparam logic [23:0] CFP_OFS_WCHK = 24'h30010c;

  // ****************************************************************
  // field positions and masks
  // ****************************************************************
  localparam int CFP_BIT_DEBUG = 7;
  localparam int CFP_BIT_LVP = 2;
  localparam int CFP_BIT_STACK = 0;
  localparam int CFP_BIT_EEPROM = 7;
  localparam int CFP_BIT_BOOT = 6;
  localparam int CFP_BIT_CFGSP = 5;
  localparam logic [7:0] CFP_MASK_DBGCFG = 8'h85;
  localparam logic [7:0] CFP_MASK_CPHI = 8'hc0;
  localparam logic [7:0] CFP_MASK_WPHI = 8'he0;

  // ****************************************************************
  // unprogrammed (erased) values and address ranges
  // ****************************************************************
  localparam logic [7:0] CFP_ERASED = 8'hff;
  localparam logic [20:0] CFP_BOOT_END_SMALL = 21'h0007ff;
  localparam logic [20:0] CFP_BOOT_END_LARGE = 21'h0001ff;
  localparam logic [20:0] CFP_CFG_BASE = 21'h000000;
  localparam logic [23:0] CFP_CFGSP_LO = 24'h300000;
  localparam logic [23:0] CFP_CFGSP_HI = 24'h3000ff;
  localparam logic [20:0] CFP_SMALL_TOP = 21'h007fff;
  localparam logic [20:0] CFP_LARGE_TOP = 21'h00ffff;
  localparam logic [20:0] CFP_UPPER_TOP = 21'h01ffff;

  // memory variant
  typedef enum logic [1:0] {
    CFP_VAR_SMALL = 2'b00,
    CFP_VAR_MID = 2'b01,
    CFP_VAR_LARGE = 2'b10
  } cfp_variant_t;

  // decoded fuse results
  typedef struct packed {
    logic debugPinsDedicated;
    logic lowVoltProgEnable;
    logic stackFaultResetEnable;
    logic [7:0] codeGuard;
    logic eepromCodeGuard;
    logic bootCodeGuard;
    logic [7:0] writeGuard;
    logic eepromWriteGuard;
    logic bootWriteGuard;
    logic configSpaceWriteGuard;
  } cfp_decode_t;

  // flash write/erase request toward the array
  typedef struct packed {
    logic valid;
    logic isEeprom;
    logic [23:0] addr;
  } cfp_wreq_t;

  localparam logic [1:0] CFP_RESP_OKAY = 2'b00;
  localparam logic [1:0] CFP_RESP_SLVERR = 2'b10;
  localparam logic [1:0] CFP_RESP_DECERR = 2'b11;

endpackage

// ==== tb/cfp_prog_model.sv ====
// ****************************************************************
// programmer model: register bus master toward the fuse bytes
// ****************************************************************
module cfp_prog_model #(
  parameter bit HAS_UPPER = 1'b1
) (
  input wire logic clock,
  output logic [31:0] s_axi_awaddr,
  output logic s_axi_awvalid,
  input wire logic s_axi_awready,
  output logic [31:0] s_axi_wdata,
  output logic [3:0] s_axi_wstrb,
  output logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  output logic s_axi_bready,
  output logic [31:0] s_axi_araddr,
  output logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  output logic s_axi_rready
);
  timeunit 1ns;
  timeprecision 100ps;

  // idle bus at time zero
  initial begin
    {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wstrb, s_axi_wvalid} = '0;
    {s_axi_bready, s_axi_araddr, s_axi_arvalid, s_axi_rready} = '0;
  end

  // handshakes are sampled at the falling edge, equal to the next rising edge
  task automatic axWrite(input logic [31:0] a, input logic [31:0] d, input logic [3:0] s,
    output logic [1:0] r, output bit ok);
    logic ta, tw, tb;
    begin
      @(posedge clock);
      s_axi_awaddr <= a;
      // parts without upper blocks keep those guard bits at 1
      s_axi_wdata <= (!HAS_UPPER && a == 32'h00300008) ? (d | 32'h00f000f0) : d;
      s_axi_wstrb <= s;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      ok = 1'b0;
      for (int n = 0; n < 64 && !ok; n++) begin
        @(negedge clock);
        ta = s_axi_awvalid & s_axi_awready;
        tw = s_axi_wvalid & s_axi_wready;
        tb = s_axi_bvalid & s_axi_bready;
        r = s_axi_bresp;
        @(posedge clock);
        if (ta) s_axi_awvalid <= 1'b0;
        if (tw) s_axi_wvalid <= 1'b0;
        if (tb) s_axi_bready <= 1'b0;
        ok = tb;
      end
    end
  endtask

  task automatic axRead(input logic [31:0] a, output logic [31:0] d, output logic [1:0] r,
    output bit ok);
    logic ta, tr;
    begin
      @(posedge clock);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      ok = 1'b0;
      for (int n = 0; n < 64 && !ok; n++) begin
        @(negedge clock);
        ta = s_axi_arvalid & s_axi_arready;
        tr = s_axi_rvalid & s_axi_rready;
        d = s_axi_rdata;
        r = s_axi_rresp;
        @(posedge clock);
        if (ta) s_axi_arvalid <= 1'b0;
        if (tr) s_axi_rready <= 1'b0;
        ok = tr;
      end
    end
  endtask
endmodule

// ==== tb/testbench.sv ====
// ****************************************************************
// fuse decode bench
// ****************************************************************
module testbench import cfp_pkg::*;;
  timeunit 1ns;
  timeprecision 100ps;

  logic clock = 1'b0, rst_n = 1'b0, userMode = 1'b0, watchdog_fuse_enable = 1'b1;
  logic stackFault = 1'b1;
  cfp_wreq_t flashReqIn = '0, flashReqOut;
  cfp_decode_t decoded;
  logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic flashReqBlocked, dbgClk, dbgDat, stackFaultReset, watchdogRun;
  int failCount = 0, compares = 0;

  // 100 MHz clock
  always #5 clock = ~clock;

  cfp_config_fuse_protection dut_u (.clock, .rst_n, .userMode, .watchdog_fuse_enable,
    .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .stackFault, .flashReqIn, .flashReqOut, .flashReqBlocked,
    .decoded, .debug_clock_port_pin(dbgClk), .debug_data_port_pin(dbgDat), .stackFaultReset,
    .watchdogRun);

  cfp_prog_model prog_u (.clock, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);

  task automatic results();
    $display("compares=%0d failCount=%0d", compares, failCount);
    if (failCount == 0 && compares > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    compares++;
    if (g !== e) begin
      failCount++;
      $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  // a bus wait that runs out ends the run at once
  task automatic alive(input bit ok);
    if (!ok) begin
      failCount++;
      results();
    end
  endtask

  task automatic wr(input logic [31:0] a, input logic [31:0] d, input logic [3:0] s,
    input logic [1:0] er);
    logic [1:0] r;
    bit ok;
    prog_u.axWrite(a, d, s, r, ok);
    alive(ok);
    chk(32'(r), 32'(er));
  endtask

  task automatic rd(input logic [31:0] a, input logic [31:0] m, input logic [31:0] e,
    input logic [1:0] er);
    logic [31:0] d;
    logic [1:0] r;
    bit ok;
    prog_u.axRead(a, d, r, ok);
    alive(ok);
    chk(32'(r), 32'(er));
    if (er == CFP_RESP_OKAY) chk(d & m, e);
  endtask

  // reset held for four rising edges
  task automatic doReset();
    @(posedge clock);
    rst_n <= 1'b0;
    repeat (4) @(posedge clock);
    rst_n <= 1'b1;
  endtask

  task automatic decodeIs(input cfp_decode_t e, input logic pins, input logic sr);
    @(negedge clock);
    chk(32'(decoded), 32'(e));
    chk({30'h0, dbgClk, dbgDat}, {30'h0, pins, pins});
    chk(32'(stackFaultReset), 32'(sr));
  endtask

  task automatic scnErased();
    decodeIs('{1'b0, 1'b1, 1'b1, 8'h00, 1'b0, 1'b0, 8'h00, 1'b0, 1'b0, 1'b0}, 1'b0, 1'b1);
    @(posedge clock);
    stackFault <= 1'b0;
    @(negedge clock);
    chk(32'(stackFaultReset), 32'h0);
    @(posedge clock);
    stackFault <= 1'b1;
    rd(32'h00300004, 32'h00ff0000, 32'h00850000, CFP_RESP_OKAY);
    rd(32'h00300008, 32'hffffffff, 32'he0ffc0ff, CFP_RESP_OKAY);
  endtask

  // unimplemented bits are written as 1 and must still read 0
  task automatic scnProgram();
    cfp_decode_t erased;
    erased = decoded;
    wr(32'h00300004, 32'h007e0000, 4'b0100, CFP_RESP_OKAY);
    wr(32'h00300008, 32'h1ffb7ffe, 4'b1111, CFP_RESP_OKAY);
    rd(32'h00300004, 32'h00ff0000, 32'h00040000, CFP_RESP_OKAY);
    rd(32'h00300008, 32'hffffffff, 32'h00fb40fe, CFP_RESP_OKAY);
    @(negedge clock);
    chk(32'(decoded), 32'(erased));
    doReset();
    decodeIs('{1'b1, 1'b1, 1'b0, 8'h01, 1'b1, 1'b0, 8'h04, 1'b1, 1'b1, 1'b1}, 1'b1, 1'b0);
  endtask

  task automatic flashCase(input logic [23:0] a, input logic ee, input logic eb);
    @(posedge clock);
    flashReqIn <= '{1'b1, ee, a};
    @(negedge clock);
    chk(32'(flashReqBlocked), 32'(eb));
    chk(32'(flashReqOut.valid), 32'(!eb));
  endtask

  task automatic scnFlashGate();
    @(posedge clock);
    userMode <= 1'b1;
    flashCase(24'h008000, 1'b0, 1'b1);
    flashCase(24'h00bfff, 1'b0, 1'b1);
    flashCase(24'h00c000, 1'b0, 1'b0);
    flashCase(24'h0001ff, 1'b0, 1'b1);
    flashCase(24'h000200, 1'b0, 1'b0);
    flashCase(24'h014000, 1'b0, 1'b0);
    flashCase(24'h000010, 1'b1, 1'b1);
    flashCase(24'h300010, 1'b0, 1'b1);
    flashReqIn <= '0;
  endtask

  // the eeprom code guard, cleared earlier, cannot be set again
  task automatic scnGuards();
    wr(32'h00300008, 32'hffffffff, 4'b1111, CFP_RESP_SLVERR);
    userMode <= 1'b0;
    wr(32'h00300008, 32'h0000c000, 4'b0010, CFP_RESP_OKAY);
    rd(32'h00300008, 32'hffffffff, 32'h00fb40fe, CFP_RESP_OKAY);
    rd(32'h00300200, 32'h0, 32'h0, CFP_RESP_DECERR);
  endtask

  // fuse-enabled watchdog ignores the software bit
  task automatic scnWatchdog();
    wr(32'h00300108, 32'h0, 4'b1111, CFP_RESP_OKAY);
    @(negedge clock);
    chk(32'(watchdogRun), 32'h1);
    @(posedge clock);
    watchdog_fuse_enable <= 1'b0;
    repeat (4) @(posedge clock);
    @(negedge clock);
    chk(32'(watchdogRun), 32'h0);
    wr(32'h00300108, 32'h1, 4'b1111, CFP_RESP_OKAY);
    @(negedge clock);
    chk(32'(watchdogRun), 32'h1);
  endtask

  initial begin
    // rst_n is low from time zero, so four edges see it low
    repeat (4) @(posedge clock);
    rst_n <= 1'b1;
    repeat (3) @(posedge clock);
    scnErased();
    scnProgram();
    scnFlashGate();
    scnGuards();
    scnWatchdog();
    results();
  end
endmodule
